// ---- hdl/eag_regs.svh ----
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

// ----------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------
`define EAG_WORD_W      16
`define EAG_PHYS_W      20
`define EAG_SEG_SHIFT   4
`define EAG_DISP8_SIGN  7
`define EAG_PARITY_BIT  2
`define EAG_NIBBLE_W    4
`define EAG_STR_LEN_W   17
`define EAG_STR_LEN_MAX 17'h10000
`define EAG_DIGIT_MAX   4'h9
`define EAG_CS_RESET    16'hFFFF
`define EAG_SEG_RESET   16'h0000

`endif

// ---- hdl/eag_pkg.sv ----
package eag_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      EAG_SEG_EXTRA = 2'h0,
      EAG_SEG_CS    = 2'h1,
      EAG_SEG_SS    = 2'h2,
      EAG_SEG_DATA  = 2'h3
   } eag_seg_e;

   typedef enum logic [2:0] {
      EAG_MODE_DIRECT   = 3'h0,
      EAG_MODE_REG_IND  = 3'h1,
      EAG_MODE_BASED    = 3'h2,
      EAG_MODE_INDEXED  = 3'h3,
      EAG_MODE_BI       = 3'h4,
      EAG_MODE_BI_DISP  = 3'h5
   } eag_mode_e;

   // Reference class that picks the implicit segment
   typedef enum logic [1:0] {
      EAG_REF_FETCH  = 2'h0,
      EAG_REF_STACK  = 2'h1,
      EAG_REF_STRDST = 2'h2,
      EAG_REF_DATA   = 2'h3
   } eag_ref_e;

   typedef struct packed {
      eag_mode_e   mode;
      eag_ref_e    kind;
      logic        base_sel;   // 0 base_general_reg, 1 base_pointer_reg
      logic        index_sel;  // 0 source index, 1 destination_index_reg
      logic [1:0]  ind_sel;    // Indirect: src idx, dst idx, base, base ptr
      logic        disp_wide;
      logic [15:0] disp;
      logic        ovr_valid;
      eag_seg_e    ovr_seg;
   } eag_req_s;

   typedef struct packed {
      logic [15:0] code_seg;
      logic [15:0] data_segment_reg;
      logic [15:0] stack_seg;
      logic [15:0] extra_segment_reg;
      logic [15:0] base_general_reg;
      logic [15:0] base_pointer_reg;
      logic [15:0] source_index;
      logic [15:0] destination_index_reg;
   } eag_regs_s;

   typedef struct packed {
      logic [15:0] offset;
      eag_seg_e    seg;
      logic [19:0] phys;
   } eag_addr_s;

   typedef enum logic [2:0] {
      EAG_ST_RUN  = 3'b001,
      EAG_ST_HALT = 3'b010,
      EAG_ST_WAIT = 3'b100
   } eag_state_e;

endpackage

// ---- hdl/eag_offset_adder.sv ----
`include "eag_regs.svh"

// ----------------------------------------------------------------------
// Offset adder: displacement plus base plus index, modulo 2^16
// ----------------------------------------------------------------------
module eag_offset_adder
   import eag_pkg::*;
(
   input  wire logic [15:0] disp,      // Raw displacement
   input  wire logic        disp_wide, // Displacement is 16 bits
   input  wire logic        use_disp,  // Displacement selected
   input  wire logic [15:0] base,      // Base element
   input  wire logic        use_base,  // Base selected
   input  wire logic [15:0] index,     // Index element
   input  wire logic        use_index, // Index selected
   output logic      [15:0] offset     // Effective offset
);

   wire logic [15:0] disp_ext;
   wire logic [15:0] term_d;
   wire logic [15:0] term_b;
   wire logic [15:0] term_i;

   // Sign extension of a short displacement
   assign disp_ext = disp_wide ? disp :
      {{8{disp[`EAG_DISP8_SIGN]}}, disp[7:0]};
   assign term_d   = use_disp  ? disp_ext : 16'h0000;
   assign term_b   = use_base  ? base     : 16'h0000;
   assign term_i   = use_index ? index    : 16'h0000;
   // Carry out of bit 15 dropped by the 16-bit target
   assign offset   = term_d + term_b + term_i;

endmodule

// ---- hdl/eag_top.sv ----
`include "eag_regs.svh"

module eag_top
   import eag_pkg::*;
(
   input  wire logic        clk,           // 250 MHz core clock
   input  wire logic        srst,          // Synchronous reset, high
   // Address request
   input  wire logic        req_valid,     // Operand address request
   input  wire eag_req_s    req,           // Request fields
   output eag_addr_s        addr,          // Registered address result
   output logic             addr_valid,    // Result strobe, one cycle
   // Segment and pointer registers
   input  wire logic        ptr_load,      // Load 32-bit far pointer
   input  wire eag_seg_e    ptr_seg,       // Segment register to reload
   input  wire logic [31:0] ptr_value,     // Segment high, offset low
   input  wire logic        seg_wr,        // Plain segment write
   input  wire eag_seg_e    seg_wr_sel,    // Segment written
   input  wire logic [15:0] seg_wr_data,   // Segment value
   input  wire logic [15:0] base_general_reg,      // Base register
   input  wire logic [15:0] base_pointer_reg,      // Base pointer register
   input  wire logic [15:0] source_index,          // Source index
   input  wire logic [15:0] destination_index_reg, // Destination index
   output logic      [15:0] ptr_offset,    // Offset from last far pointer
   // Operand interpretation
   input  wire logic [15:0] operand,       // Operand value
   input  wire logic        operand_word,  // Operand is a word
   output logic signed [16:0] operand_signed, // Signed value, widened
   output logic       [7:0] packed_digits, // Binary value of packed BCD
   output logic             packed_bad,    // Nibble above nine
   input  wire logic [16:0] str_len,       // Requested string length
   output logic             str_len_ok,    // Length within 1..64K
   // Control
   input  wire logic        halt_instruction, // Halt executed, pulse
   input  wire logic        wait_instr,    // Wait executed, pulse
   input  wire logic        test_pin_n,    // Test pin, active low
   input  wire logic        intr,          // Interrupt pending
   input  wire logic        lock_prefix,   // Lock prefix seen, pulse
   input  wire logic        instr_end,     // Instruction completes, pulse
   output logic             run,           // Execution may proceed
   output logic             bus_lock_n,    // Local bus lock, low
   // Conditional jumps
   input  wire logic        jump_if_count_zero,   // Count-zero jump op
   input  wire logic        jump_on_parity_even,  // Parity-even jump op
   input  wire logic        jump_on_parity_odd,   // Parity-odd jump op
   input  wire logic [15:0] count_reg,     // Count register
   input  wire logic [15:0] flags,         // Status word
   output logic             jump_taken     // Registered jump decision
);

   // ----------------------------------------------------------------------
   // Segment register file
   // ----------------------------------------------------------------------
   logic [15:0] seg_file [4];
   logic [15:0] ptr_off_q;

   // Far pointer load wins over a plain write in the same cycle.
   // Code segment resets high so the first fetch hits the restart
   // address near the top of memory.
   always_ff @(posedge clk) begin
      if (srst) begin
         seg_file[EAG_SEG_EXTRA] <= `EAG_SEG_RESET;
         seg_file[EAG_SEG_CS]    <= `EAG_CS_RESET;
         seg_file[EAG_SEG_SS]    <= `EAG_SEG_RESET;
         seg_file[EAG_SEG_DATA]  <= `EAG_SEG_RESET;
         ptr_off_q               <= 16'h0000;
      end else if (ptr_load) begin
         seg_file[ptr_seg] <= ptr_value[31:16];
         ptr_off_q         <= ptr_value[15:0];
      end else if (seg_wr) begin
         seg_file[seg_wr_sel] <= seg_wr_data;
      end
   end

   assign ptr_offset = ptr_off_q;

   // ----------------------------------------------------------------------
   // Segment selection
   // ----------------------------------------------------------------------
   wire logic stack_base;
   wire logic mode_has_base;
   wire logic ind_stack;
   eag_seg_e  implicit_seg;
   eag_seg_e  final_seg;

   // A base pointer element, as base or as the sole indirect
   // register, steers a data reference to the stack segment
   assign mode_has_base = (req.mode == EAG_MODE_BASED) ||
                          (req.mode == EAG_MODE_BI) ||
                          (req.mode == EAG_MODE_BI_DISP);
   assign ind_stack     = (req.mode == EAG_MODE_REG_IND) &&
                          (req.ind_sel == 2'h3);
   assign stack_base    = (mode_has_base && req.base_sel) || ind_stack;

   // Implicit segment from the reference class
   always_comb begin
      unique case (req.kind)
         EAG_REF_FETCH:  implicit_seg = EAG_SEG_CS;
         EAG_REF_STACK:  implicit_seg = EAG_SEG_SS;
         EAG_REF_STRDST: implicit_seg = EAG_SEG_EXTRA;
         EAG_REF_DATA:
            implicit_seg = stack_base ? EAG_SEG_SS
                                      : EAG_SEG_DATA;
      endcase
   end

   // Override wins over every implicit choice, fetches included
   assign final_seg = req.ovr_valid ? req.ovr_seg
                                    : implicit_seg;

   // ----------------------------------------------------------------------
   // Element selection per addressing mode
   // ----------------------------------------------------------------------
   logic [15:0] base_val;
   logic [15:0] index_val;
   logic        use_disp;
   logic        use_base;
   logic        use_index;

   // Defaults give the plain base and index picks; register
   // indirect reroutes the index path to any of the four
   always_comb begin
      base_val  = req.base_sel  ? base_pointer_reg : base_general_reg;
      index_val = req.index_sel ? destination_index_reg : source_index;
      use_disp  = 1'b0;
      use_base  = 1'b0;
      use_index = 1'b0;
      unique case (req.mode)
         EAG_MODE_DIRECT: begin
            use_disp = 1'b1;
         end
         EAG_MODE_REG_IND: begin
            unique case (req.ind_sel)
               2'h0: index_val = source_index;
               2'h1: index_val = destination_index_reg;
               2'h2: index_val = base_general_reg;
               2'h3: index_val = base_pointer_reg;
            endcase
            use_index = 1'b1;
         end
         EAG_MODE_BASED: begin
            use_disp = 1'b1;
            use_base = 1'b1;
         end
         EAG_MODE_INDEXED: begin
            use_disp  = 1'b1;
            use_index = 1'b1;
         end
         EAG_MODE_BI: begin
            use_base  = 1'b1;
            use_index = 1'b1;
         end
         EAG_MODE_BI_DISP: begin
            use_disp  = 1'b1;
            use_base  = 1'b1;
            use_index = 1'b1;
         end
         default: begin
            use_disp = 1'b1;
         end
      endcase
   end

   wire logic [15:0] eff_off;

   eag_offset_adder u_adder (
      .disp      (req.disp),
      .disp_wide (req.disp_wide),
      .use_disp  (use_disp),
      .base      (base_val),
      .use_base  (use_base),
      .index     (index_val),
      .use_index (use_index),
      .offset    (eff_off)
   );

   // ----------------------------------------------------------------------
   // Physical address
   // ----------------------------------------------------------------------
   wire logic [19:0] seg_shift;
   wire logic [19:0] next_phys;

   // Segment base moved up four bits; the 20-bit sum wraps at the top
   assign seg_shift = {seg_file[final_seg], 4'h0};
   assign next_phys = seg_shift + {4'h0, eff_off};

   // Result holds until the next accepted request
   always_ff @(posedge clk) begin
      if (srst) begin
         addr       <= '0;
         addr_valid <= 1'b0;
      end else begin
         addr_valid <= req_valid && run;
         if (req_valid && run) begin
            addr <= '{offset: eff_off, seg: final_seg, phys: next_phys};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Operand interpretation
   // ----------------------------------------------------------------------
   wire logic [3:0] digit_hi;
   wire logic [3:0] digit_lo;

   // Two's complement widening of a byte or word
   assign operand_signed = operand_word ?
      {operand[15], operand} : {{9{operand[7]}}, operand[7:0]};
   assign digit_hi      = operand[7:4];
   assign digit_lo      = operand[3:0];
   assign packed_digits = 8'(({4'h0, digit_hi} << 3) +
                             ({4'h0, digit_hi} << 1) + {4'h0, digit_lo});
   assign packed_bad    = (digit_hi > `EAG_DIGIT_MAX) ||
                          (digit_lo > `EAG_DIGIT_MAX);
   assign str_len_ok    = (str_len != 17'h00000) &&
                          (str_len <= `EAG_STR_LEN_MAX);

   // ----------------------------------------------------------------------
   // Test pin synchroniser
   // ----------------------------------------------------------------------
   logic test_meta_n;
   logic test_sync_n;

   // Only the second stage feeds logic; the first may go metastable
   always_ff @(posedge clk) begin
      if (srst) begin
         test_meta_n <= 1'b1;
         test_sync_n <= 1'b1;
      end else begin
         test_meta_n <= test_pin_n;
         test_sync_n <= test_meta_n;
      end
   end

   // ----------------------------------------------------------------------
   // Execution state: run, halt, wait
   // ----------------------------------------------------------------------
   eag_state_e state;
   eag_state_e next_state;

   // Halt beats wait; both are ignored unless running, and a wait
   // with the pin already active does not stop at all
   always_comb begin
      next_state = state;
      unique case (state)
         EAG_ST_RUN: begin
            if (halt_instruction) begin
               next_state = EAG_ST_HALT;
            end else if (wait_instr && test_sync_n) begin
               next_state = EAG_ST_WAIT;
            end
         end
         EAG_ST_HALT: begin
            if (intr) begin
               next_state = EAG_ST_RUN;
            end
         end
         EAG_ST_WAIT: begin
            if (!test_sync_n) begin
               next_state = EAG_ST_RUN;
            end
         end
         default: next_state = EAG_ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= EAG_ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   assign run = (state == EAG_ST_RUN);

   // ----------------------------------------------------------------------
   // Bus lock across the next instruction
   // ----------------------------------------------------------------------
   logic lock_armed;
   logic lock_active;

   // Prefix locks and arms. The prefix's own end disarms but keeps
   // the lock; the end of the locked instruction then releases it.
   // A prefix in the same cycle as an end wins.
   always_ff @(posedge clk) begin
      if (srst) begin
         lock_armed  <= 1'b0;
         lock_active <= 1'b0;
      end else if (lock_prefix) begin
         lock_armed  <= 1'b1;
         lock_active <= 1'b1;
      end else if (instr_end) begin
         lock_armed  <= 1'b0;
         lock_active <= lock_armed;
      end
   end

   assign bus_lock_n = !lock_active;

   // ----------------------------------------------------------------------
   // Conditional jump decision
   // ----------------------------------------------------------------------
   wire logic parity_set;
   wire logic next_jump;

   assign parity_set = flags[`EAG_PARITY_BIT];
   assign next_jump  =
      (jump_if_count_zero  && (count_reg == 16'h0000)) ||
      (jump_on_parity_even &&  parity_set) ||
      (jump_on_parity_odd  && !parity_set);

   // Decision registered, one cycle per strobe
   always_ff @(posedge clk) begin
      if (srst) begin
         jump_taken <= 1'b0;
      end else begin
         jump_taken <= next_jump;
      end
   end

endmodule

// ---- verif/eag_top_sva.sv ----
module eag_top_sva
   import eag_pkg::*;
(
   input wire logic        clk,                   // Clock
   input wire logic        srst,                  // Reset
   input wire logic        req_valid,             // Request
   input wire eag_req_s    req,                   // Fields
   input wire eag_addr_s   addr,                  // Result
   input wire logic        addr_valid,            // Strobe
   input wire logic [15:0] base_general_reg,      // Base
   input wire logic [15:0] base_pointer_reg,      // Base ptr
   input wire logic [15:0] source_index,          // Src idx
   input wire logic [15:0] destination_index_reg, // Dst idx
   input wire logic        halt_instruction,      // Halt
   input wire logic        intr,                  // Interrupt
   input wire logic        run,                   // Running
   input wire logic        lock_prefix,           // Lock
   input wire logic        bus_lock_n,            // Bus lock
   input wire logic        jump_if_count_zero,    // Jump op
   input wire logic        jump_on_parity_even,   // Jump op
   input wire logic        jump_on_parity_odd,    // Jump op
   input wire logic [15:0] count_reg,             // Count
   input wire logic [15:0] flags,                 // Status
   input wire logic        jump_taken             // Decision
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic [15:0] dx, bsel, xsel, isel, exp_off;
   logic        stack_base, exp_jump, halted;
   eag_seg_e    exp_seg;

   // Reference offset and segment for the request on the inputs
   assign dx = req.disp_wide ? req.disp : {{8{req.disp[7]}}, req.disp[7:0]};
   assign bsel = req.base_sel ? base_pointer_reg : base_general_reg;
   assign xsel = req.index_sel ? destination_index_reg : source_index;
   assign isel = req.ind_sel[1] ?
      (req.ind_sel[0] ? base_pointer_reg : base_general_reg) :
      (req.ind_sel[0] ? destination_index_reg : source_index);
   assign exp_off = (req.mode == EAG_MODE_DIRECT) ? dx :
                    (req.mode == EAG_MODE_REG_IND) ? isel :
                    (req.mode == EAG_MODE_BASED) ? dx + bsel :
                    (req.mode == EAG_MODE_INDEXED) ? dx + xsel :
                    (req.mode == EAG_MODE_BI) ? bsel + xsel :
                    dx + bsel + xsel;
   assign stack_base = (req.mode == EAG_MODE_REG_IND) ? (req.ind_sel == 2'h3) :
      (req.mode != EAG_MODE_DIRECT && req.mode != EAG_MODE_INDEXED &&
       req.base_sel);
   assign exp_seg = req.ovr_valid ? req.ovr_seg :
                    (req.kind == EAG_REF_FETCH) ? EAG_SEG_CS :
                    (req.kind == EAG_REF_STACK) ? EAG_SEG_SS :
                    (req.kind == EAG_REF_STRDST) ? EAG_SEG_EXTRA :
                    stack_base ? EAG_SEG_SS : EAG_SEG_DATA;
   assign exp_jump = (jump_if_count_zero && count_reg == 16'h0000) ||
                     (jump_on_parity_even && flags[2]) ||
                     (jump_on_parity_odd && !flags[2]);

   // Remembers that the stop came from a halt, not a wait
   always_ff @(posedge clk) begin
      if (srst) begin
         halted <= 1'b0;
      end else if (halt_instruction && run) begin
         halted <= 1'b1;
      end else if (run) begin
         halted <= 1'b0;
      end
   end

   sequence s_accept;
      req_valid && run;
   endsequence
   sequence s_halt;
      halt_instruction && run;
   endsequence

   valid_pulse_a: assert property (s_accept |=> addr_valid)
      else $error("address result missing");
   valid_idle_a: assert property
      (!(req_valid && run) |=> !addr_valid)
      else $error("address result without request");
   offset_sum_a: assert property
      (s_accept |=> addr.offset == $past(exp_off))
      else $error("effective offset wrong");
   seg_select_a: assert property
      (s_accept |=> addr.seg == $past(exp_seg))
      else $error("segment choice wrong");
   halt_stop_a: assert property (s_halt |=> !run)
      else $error("halt did not stop");
   halt_exit_a: assert property
      (halted && !run |=> run == $past(intr))
      else $error("halt exit wrong");
   lock_start_a: assert property (lock_prefix |=> !bus_lock_n)
      else $error("bus not locked");
   jump_decide_a: assert property
      (jump_taken == $past(exp_jump))
      else $error("jump decision wrong");
endmodule

bind eag_top eag_top_sva eag_top_sva_i (
   .clk, .srst, .req_valid, .req, .addr, .addr_valid,
   .base_general_reg, .base_pointer_reg, .source_index,
   .destination_index_reg, .halt_instruction, .intr, .run,
   .lock_prefix, .bus_lock_n, .jump_if_count_zero,
   .jump_on_parity_even, .jump_on_parity_odd, .count_reg, .flags,
   .jump_taken
);

// ---- verif/eag_test_party.sv ----
module eag_test_party
(
   input  wire logic clk,       // Clock
   input  wire logic srst,      // Reset
   input  wire logic go,        // Release request
   output logic      test_pin_n // Test pin, low
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 4;
   int cnt = 0;

   // Pin idles inactive, goes active some cycles after go
   always @(posedge clk) begin
      if (srst || !go) begin
         cnt <= 0;
         test_pin_n <= 1'b1;
      end else if (cnt == DLY) begin
         test_pin_n <= 1'b0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// ---- verif/tb.sv ----
module tb
   import eag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, srst = 1'b1, req_valid = 1'b0, pin_go = 1'b0;
   logic        ptr_load = 1'b0, seg_wr = 1'b0, operand_word = 1'b0;
   logic        jump_if_count_zero = 1'b0, jump_on_parity_even = 1'b0;
   logic        jump_on_parity_odd = 1'b0;
   logic [4:0]  st = 5'h00;
   eag_req_s    req = '0;
   eag_seg_e    ptr_seg = EAG_SEG_EXTRA, seg_wr_sel = EAG_SEG_EXTRA;
   logic [31:0] ptr_value = 32'h0000_0000;
   logic [15:0] seg_wr_data = 16'h0000, operand = 16'h0000;
   logic [15:0] count_reg = 16'h0000, flags = 16'h0000;
   logic [15:0] base_general_reg = 16'h8001, base_pointer_reg = 16'h9002;
   logic [15:0] source_index = 16'hF004, destination_index_reg = 16'h0FF8;
   logic [16:0] str_len = 17'h00000, op_signed;
   eag_addr_s   addr;
   logic        addr_valid, run, bus_lock_n, jump_taken, packed_bad;
   logic        str_len_ok, test_pin_n;
   logic [15:0] ptr_offset;
   logic [7:0]  packed_digits;
   int          fail_count = 0, checked = 0, nv = 0, cycles = 0;
   wire logic   halt_instruction = st[0], wait_instr = st[1];
   wire logic   lock_prefix = st[2], instr_end = st[3], intr = st[4];

   eag_top eag_top_i (
      .clk, .srst, .req_valid, .req, .addr, .addr_valid, .ptr_load,
      .ptr_seg, .ptr_value, .seg_wr, .seg_wr_sel, .seg_wr_data,
      .base_general_reg, .base_pointer_reg, .source_index,
      .destination_index_reg, .ptr_offset, .operand, .operand_word,
      .operand_signed(op_signed), .packed_digits, .packed_bad, .str_len,
      .str_len_ok, .halt_instruction, .wait_instr, .test_pin_n, .intr,
      .lock_prefix, .instr_end, .run, .bus_lock_n, .jump_if_count_zero,
      .jump_on_parity_even, .jump_on_parity_odd, .count_reg, .flags,
      .jump_taken
   );
   eag_test_party eag_test_party_i (.clk, .srst, .go(pin_go), .test_pin_n);

   // Clock, result counter and hang guard
   initial forever #2 clk = ~clk;
   always @(negedge clk) if (addr_valid === 1'b1) nv++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   function automatic eag_req_s mk(eag_mode_e m, eag_ref_e k,
      logic [15:0] d, logic w, logic [1:0] s, logic ov,
      eag_seg_e os = EAG_SEG_EXTRA);
      return '{m, k, s[0], s[1], s, w, d, ov, os};
   endfunction

   // One request, result sampled once it has settled
   task automatic send(eag_req_s r);
      @(posedge clk);
      req <= r;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
   endtask

   task automatic pulse(int b);
      @(posedge clk);
      st[b] <= 1'b1;
      @(posedge clk);
      st[b] <= 1'b0;
      @(negedge clk);
   endtask

   // Plain segment write, or far pointer with a clashing plain write
   task automatic wr_seg(logic p, eag_seg_e s, logic [31:0] v);
      @(posedge clk);
      ptr_load <= p;
      ptr_seg <= s;
      ptr_value <= v;
      seg_wr <= 1'b1;
      seg_wr_sel <= s;
      seg_wr_data <= p ? 16'h0000 : v[31:16];
      @(posedge clk);
      ptr_load <= 1'b0;
      seg_wr <= 1'b0;
      @(negedge clk);
   endtask

   task automatic t_segs;
      chk(run, 1'b1);
      chk(bus_lock_n, 1'b1);
      send(mk(EAG_MODE_DIRECT, EAG_REF_FETCH, 16'h0000, 1'b1, 2'h0, 1'b0));
      chk(addr.phys, 20'hFFFF0);
      wr_seg(1'b0, EAG_SEG_DATA, 32'h1234_0000);
      send(mk(EAG_MODE_DIRECT, EAG_REF_DATA, 16'h0010, 1'b1, 2'h0, 1'b0));
      chk(addr.phys, 20'h12350);
      wr_seg(1'b1, EAG_SEG_EXTRA, 32'hF000_FFFF);
      chk(ptr_offset, 16'hFFFF);
      send(mk(EAG_MODE_DIRECT, EAG_REF_STRDST, 16'h0000, 1'b1, 2'h0, 1'b0));
      chk(addr.phys, 20'hF0000);
      send(mk(EAG_MODE_DIRECT, EAG_REF_DATA, 16'h0001, 1'b1, 2'h0, 1'b1));
      chk(addr.phys, 20'hF0001);
      wr_seg(1'b0, EAG_SEG_SS, 32'h0100_0000);
      send(mk(EAG_MODE_BASED, EAG_REF_DATA, 16'h00FE, 1'b0, 2'h1, 1'b0));
      chk(addr.phys, 20'h0A000);
      $display("segment test done");
   endtask

   // Every mode, kind and override, back to back
   task automatic t_modes;
      int n0;
      @(posedge clk);
      n0 = nv;
      for (int i = 0; i < 384; i++) begin
         req <= mk(eag_mode_e'(i % 6), eag_ref_e'((i / 6) % 4),
            (i / 96) % 2 ? 16'h7FFF : 16'h0080, 1'((i / 96) % 2),
            2'((i / 24) % 4), 1'(i / 192), eag_seg_e'(i % 4));
         req_valid <= 1'b1;
         @(posedge clk);
      end
      req_valid <= 1'b0;
      repeat (2) @(negedge clk);
      chk(nv - n0, 384);
      $display("mode test done");
   endtask

   task automatic opnd(logic [15:0] v, logic w, logic [16:0] e);
      @(posedge clk);
      operand <= v;
      operand_word <= w;
      @(negedge clk);
      chk(op_signed, e);
   endtask

   task automatic t_data;
      logic [16:0] lens [4] = '{17'h00000, 17'h00001, 17'h10000, 17'h10001};
      opnd(16'h0080, 1'b0, 17'h1FF80);
      opnd(16'h127F, 1'b0, 17'h0007F);
      opnd(16'h8000, 1'b1, 17'h18000);
      opnd(16'h0059, 1'b1, 17'h00059);
      chk(packed_digits, 8'h3B);
      chk(packed_bad, 1'b0);
      opnd(16'h00A0, 1'b1, 17'h000A0);
      chk(packed_bad, 1'b1);
      foreach (lens[j]) begin
         @(posedge clk);
         str_len <= lens[j];
         @(negedge clk);
         chk(str_len_ok, j == 1 || j == 2);
      end
      $display("data test done");
   endtask

   task automatic t_ctrl;
      int n0;
      int k = 0;
      pulse(0);
      chk(run, 1'b0);
      n0 = nv;
      send(mk(EAG_MODE_DIRECT, EAG_REF_DATA, 16'h0000, 1'b1, 2'h0, 1'b0));
      pulse(1);
      repeat (5) @(negedge clk);
      chk(run, 1'b0);
      chk(nv - n0, 0);
      pulse(4);
      chk(run, 1'b1);
      pulse(1);
      chk(run, 1'b0);
      @(posedge clk);
      pin_go <= 1'b1;
      while (run !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(k >= 6 && k < 20, 1'b1);
      @(posedge clk);
      pin_go <= 1'b0;
      pulse(2);
      chk(bus_lock_n, 1'b0);
      pulse(3);
      repeat (3) @(negedge clk);
      chk(bus_lock_n, 1'b0);
      pulse(3);
      chk(bus_lock_n, 1'b1);
      $display("control test done");
   endtask

   // Each jump op with its condition met and not met
   task automatic t_jump;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         jump_if_count_zero <= (i / 2 == 0);
         jump_on_parity_even <= (i / 2 == 1);
         jump_on_parity_odd <= (i / 2 == 2);
         count_reg <= (i % 2) ? 16'h0000 : 16'h0100;
         flags <= (i % 2) ? 16'h0004 : 16'hFFFB;
         @(posedge clk);
         jump_if_count_zero <= 1'b0;
         jump_on_parity_even <= 1'b0;
         jump_on_parity_odd <= 1'b0;
         @(negedge clk);
         chk(jump_taken, (i % 2 == 1) ^ (i / 2 == 2));
      end
      $display("jump test done");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      t_segs();
      t_modes();
      t_data();
      t_ctrl();
      t_jump();
      print_verdict();
   end
endmodule
